/* bench/acqd_regs_asserts.sv */
`timescale 1ns/1ns
`include "acqd_cfg.svh"
// ----------------------------------------
// port checker for the register bank
// ----------------------------------------
module acqd_regs_asserts (
    input wire logic core_clk, // core clock
    input wire logic reset_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic halfCycleTick, // half-cycle pulse
    input wire logic supplyChange, // supply change pulse
    input wire logic [15:0] loopError, // raw error
    input wire logic [7:0] loopDemand, // requested code
    input wire logic [15:0] loopErrorTrunc, // truncated error
    input wire logic [10:0] learnLevel, // learn level
    input wire logic learnActive, // learning running
    input wire logic adaptiveOn, // adaptive enabled
    input wire logic [7:0] appliedCurrent, // bounded current
    input wire logic quietDecayOn, // quiet decay enabled
    input wire logic [9:0] sampleCycles, // sample window
    input wire logic pwmTick // switching pulse
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // setup phase of any transfer
    sequence seqSetup;
        psel && !penable;
    endsequence
    // completed write that sets the launch bit
    sequence seqLaunch;
        psel && penable && pready && pwrite && pwdata[`ACQD_TRIGGER_BIT]
            && paddr == {2'b00, `ACQD_IDX_ADAPT_CTRL, 2'b00};
    endsequence
    chk_ready_after_setup: assert property (seqSetup |=> pready)
        else $error("ready missing after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_read_upper_zero: assert property (
        pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_learn_launch: assert property (
        seqLaunch |-> ##2 learnActive)
        else $error("learning did not start");
    chk_idle_level_zero: assert property (
        !learnActive |-> learnLevel == 11'h0)
        else $error("learn level while idle");
    // sample window must be one of the four legal lengths
    chk_sample_legal: assert property ($past(reset_n) |->
        sampleCycles inside {10'd200, 10'd300, 10'd400, 10'd500})
        else $error("illegal sample window");
    // arithmetic shift keeps the sign of the error
    chk_trunc_sign: assert property ($past(reset_n) |->
        loopErrorTrunc[15] == $past(loopError[15]))
        else $error("truncated error lost sign");
    chk_pwm_off_quiet: assert property (
        !quietDecayOn && !$past(quietDecayOn) |-> !pwmTick)
        else $error("switching pulse while disabled");
    chk_pwm_single: assert property (pwmTick |=> !pwmTick)
        else $error("switching pulse too wide");
endmodule : acqd_regs_asserts

bind acqd_regs acqd_regs_asserts i_acqd_regs_asserts (.core_clk, .reset_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .halfCycleTick, .supplyChange, .loopError, .loopDemand, .loopErrorTrunc,
    .learnLevel, .learnActive, .adaptiveOn, .appliedCurrent, .quietDecayOn,
    .sampleCycles, .pwmTick);

/* bench/acqd_regs_tb.sv */
`timescale 1ns/1ns
module acqd_regs_tb;
    logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic halfCycleTick, supplyChange, learnActive, adaptiveOn;
    logic quietDecayOn, pwmTick, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] loopError, loopErrorTrunc;
    logic [7:0] loopDemand, appliedCurrent, rd;
    logic [10:0] learnLevel;
    logic [9:0] sampleCycles;
    int n_fail, n_checks, c;
    // register indices and their reset values
    logic [7:0] rstIdx [12] = '{8'h28, 8'h29, 8'h2a, 8'h2d, 8'h2e, 8'h2f,
        8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35};
    logic [7:0] rstVal [12] = '{8'h00, 8'h0a, 8'hff, 8'h00, 8'hff, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
    logic [15:0] stepInc [4] = '{16'd128, 16'd16, 16'd32, 16'd64};
    logic [15:0] period [4] = '{16'd4000, 16'd3030, 16'd2380, 16'd2000};
    acqd_regs i_acqd_regs (.core_clk, .reset_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .halfCycleTick,
        .supplyChange, .loopError, .loopDemand, .loopErrorTrunc, .learnLevel,
        .learnActive, .adaptiveOn, .appliedCurrent, .quietDecayOn,
        .sampleCycles, .pwmTick);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    // one apb transfer; held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx,
        input logic [7:0] wd);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            test_done();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, exp, "register read");
    endtask : rdchk
    // half-cycle pulses spaced so each one settles before the next
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk) halfCycleTick <= 1'b1;
            @(posedge core_clk) halfCycleTick <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
    endtask : tick
    task automatic supply_pulse();
        @(posedge core_clk) supplyChange <= 1'b1;
        @(posedge core_clk) supplyChange <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : supply_pulse
    // bounded wait for the next switching pulse, cycles in c
    task automatic wait_pwm();
        for (c = 1; c <= 5000; c++) begin
            @(posedge core_clk);
            if (pwmTick === 1'b1) break;
        end
        if (c > 5000) begin
            n_fail++;
            test_done();
        end
    endtask : wait_pwm
    task automatic launch();
        int i;
        apb(1'b1, 8'h28, 8'hc0);
        for (i = 0; i < 16 && learnActive !== 1'b1; i++) @(posedge core_clk);
        check(learnLevel, 16'd192, "initial level");
    endtask : launch
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // watchdog so a stuck handshake still ends the run
    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        test_done();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {reset_n, psel, penable, pwrite, halfCycleTick, supplyChange} = '0;
        paddr = '0;
        pwdata = '0;
        loopError = '0;
        loopDemand = '0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (rstIdx[i]) rdchk(rstIdx[i], rstVal[i]);
        foreach (rstIdx[i]) begin
            if (i > 2 && i != 4) begin
                apb(1'b1, rstIdx[i], 8'ha5);
                rdchk(rstIdx[i], 8'ha5);
                apb(1'b1, rstIdx[i], 8'h5a);
                rdchk(rstIdx[i], 8'h5a);
            end
        end
        apb(1'b1, 8'h2e, 8'h12);
        rdchk(8'h2e, 8'hff);
        apb(1'b1, 8'h2a, 8'h80);
        rdchk(8'h2e, 8'h80);
        apb(1'b0, 8'h3f, 8'h00);
        check({err, rd}, 16'h100, "unmapped read");
        // clamp of the demanded code between floor and ceiling
        apb(1'b1, 8'h29, 8'h20);
        apb(1'b1, 8'h28, 8'h80);
        repeat (2) @(posedge core_clk);
        check(adaptiveOn, 16'h1, "adaptive enable");
        foreach (rstVal[i]) begin
            if (i < 3) begin
                loopDemand <= 8'h10 + 8'h70 * i[7:0];
                repeat (3) @(posedge core_clk);
                c = (i == 0) ? 32 : (i == 1) ? 128 : 128;
                check(appliedCurrent, c[15:0], "clamp");
                rdchk(8'h2e, c[7:0]);
            end
        end
        apb(1'b1, 8'h2d, 8'h40);
        loopError <= 16'h8f30;
        repeat (3) @(posedge core_clk);
        check(loopErrorTrunc, 16'hf8f3, "drop four");
        apb(1'b1, 8'h2d, 8'h00);
        repeat (3) @(posedge core_clk);
        check(loopErrorTrunc, 16'h8f30, "drop none");
        // every sample code and switch rate in turn
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, 8'h31, {s[1:0], 2'b00, s[1:0], 2'b01});
            repeat (2) @(posedge core_clk);
            check(sampleCycles, 16'(200 + 100 * s), "sample");
            check(quietDecayOn, 16'h1, "quiet on");
            wait_pwm();
            wait_pwm();
            check(c[15:0], period[s], "pwm period");
        end
        apb(1'b1, 8'h31, 8'h00);
        repeat (2) @(posedge core_clk);
        check(quietDecayOn, 16'h0, "quiet off");
        // learning with every step code and dwell code
        apb(1'b1, 8'h38, 8'h18);
        apb(1'b1, 8'h2f, 8'h00);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'h2d, {4'h0, k[1:0], k[1:0]});
            launch();
            tick(8 * k + 7);
            check(learnLevel, 16'd192, "dwell initial");
            tick(1);
            check(learnLevel, 16'd192 + stepInc[k], "final");
            tick(8 * k + 7);
            check(learnActive, 16'h1, "dwell final");
            tick(1);
            check(learnActive, 16'h0, "learn end");
            rdchk(8'h28, 8'h80);
        end
        // supply change restarts learning only with rescale set
        apb(1'b1, 8'h2d, 8'h00);
        apb(1'b1, 8'h2f, 8'h40);
        launch();
        tick(8);
        supply_pulse();
        check(learnLevel, 16'd192, "rescale restart");
        apb(1'b1, 8'h2f, 8'h00);
        tick(8);
        supply_pulse();
        check(learnLevel, 16'd320, "no rescale");
        tick(8);
        test_done();
    end
endmodule : acqd_regs_tb

/* design/acqd_cfg.svh */
`ifndef ACQD_CFG_SVH
`define ACQD_CFG_SVH
// --------------------------------------------------------------
// register indices (byte address is four times the index)
// --------------------------------------------------------------
`define ACQD_IDX_ADAPT_CTRL 8'h28
`define ACQD_IDX_FLOOR 8'h29
`define ACQD_IDX_CEILING 8'h2a
`define ACQD_IDX_LEARN_TUNE 8'h2d
`define ACQD_IDX_LIVE 8'h2e
`define ACQD_IDX_RESCALE 8'h2f
`define ACQD_IDX_SPARE 8'h30
`define ACQD_IDX_QD_MAIN 8'h31
`define ACQD_IDX_QD_PROP 8'h32
`define ACQD_IDX_QD_INT 8'h33
`define ACQD_IDX_QD_DIV 8'h34
`define ACQD_IDX_QD_THR 8'h35
`define ACQD_IDX_LEARN_BASE 8'h38
// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define ACQD_RST_ADAPT_CTRL 8'h00
`define ACQD_RST_FLOOR 8'h0a
`define ACQD_RST_CEILING 8'hff
`define ACQD_RST_LEARN_TUNE 8'h00
`define ACQD_RST_LIVE 8'hff
`define ACQD_RST_RESCALE 8'h00
`define ACQD_RST_SPARE 8'h00
`define ACQD_RST_QD_MAIN 8'h00
`define ACQD_RST_QD_PROP 8'h00
`define ACQD_RST_QD_INT 8'h00
`define ACQD_RST_QD_DIV 8'h00
`define ACQD_RST_QD_THR 8'hff
`define ACQD_RST_LEARN_BASE 8'h00
// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define ACQD_ADAPT_ON_BIT 7
`define ACQD_TRIGGER_BIT 6
`define ACQD_RESCALE_BIT 6
`define ACQD_QD_EN_BIT 0
// --------------------------------------------------------------
// timing: clock rate, sample times in ns, switch rates in kHz
// --------------------------------------------------------------
`define ACQD_CLK_KHZ 100000
`define ACQD_SAMPLE0_NS 2000
`define ACQD_SAMPLE1_NS 3000
`define ACQD_SAMPLE2_NS 4000
`define ACQD_SAMPLE3_NS 5000
`define ACQD_RATE0_KHZ 25
`define ACQD_RATE1_KHZ 33
`define ACQD_RATE2_KHZ 42
`define ACQD_RATE3_KHZ 50
`define ACQD_BASE_MULT 8
`define ACQD_DWELL_UNIT 8
`endif

/* design/acqd_pkg.sv */
package acqd_pkg;
    // learning sequence phases
    typedef enum logic [1:0] {
        LEARN_IDLE,
        LEARN_INITIAL,
        LEARN_FINAL
    } acqd_learn_type;
endpackage : acqd_pkg

/* design/acqd_regs.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - drop chosen count of error low bits
// - step code picks increment 128/16/32/64
// - initial level base times eight, final adds step
// - dwell 8/16/24/32 half-cycles per level
// - live code read-only, clamped floor to ceiling
// - adaptive off: live code shows ceiling
// - rescale bit restarts learning on supply change
// - quiet-decay registers readable and writable
// - sample code selects 2/3/4/5 us
// - rate code selects 25/33/42/50 kHz
// - bit zero enables quiet decay mode
// - adaptive enable bit turns function on
// - trigger launches learning, self-clears when done
// - floor and ceiling bound applied current
`include "acqd_cfg.svh"
module acqd_regs (
    input wire logic core_clk, // 100 MHz core clock
    input wire logic reset_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic halfCycleTick, // electrical half-cycle pulse
    input wire logic supplyChange, // supply voltage change pulse
    input wire logic [15:0] loopError, // signed current error
    input wire logic [7:0] loopDemand, // current code from loop
    output logic [15:0] loopErrorTrunc, // error after bit drop
    output logic [10:0] learnLevel, // current level while learning
    output logic learnActive, // learning routine running
    output logic adaptiveOn, // adaptive current enabled
    output logic [7:0] appliedCurrent, // bounded coil current
    output logic quietDecayOn, // quiet decay mode enabled
    output logic [9:0] sampleCycles, // zero-cross sample window
    output logic pwmTick // quiet decay switching pulse
);
    import acqd_pkg::*;

    // --------------------------------------------------------------
    // derived cycle counts
    // --------------------------------------------------------------
    // least times round up to whole cycles
    localparam int SAMPLE0 = (`ACQD_SAMPLE0_NS * `ACQD_CLK_KHZ
        + 999999) / 1000000;
    localparam int SAMPLE1 = (`ACQD_SAMPLE1_NS * `ACQD_CLK_KHZ
        + 999999) / 1000000;
    localparam int SAMPLE2 = (`ACQD_SAMPLE2_NS * `ACQD_CLK_KHZ
        + 999999) / 1000000;
    localparam int SAMPLE3 = (`ACQD_SAMPLE3_NS * `ACQD_CLK_KHZ
        + 999999) / 1000000;
    // switching periods round down
    localparam int PERIOD0 = `ACQD_CLK_KHZ / `ACQD_RATE0_KHZ;
    localparam int PERIOD1 = `ACQD_CLK_KHZ / `ACQD_RATE1_KHZ;
    localparam int PERIOD2 = `ACQD_CLK_KHZ / `ACQD_RATE2_KHZ;
    localparam int PERIOD3 = `ACQD_CLK_KHZ / `ACQD_RATE3_KHZ;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // bound a code between floor and ceiling
    function automatic logic [7:0] bound_code(input logic [7:0] v,
        input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end
        if (r > hi) begin
            r = hi; // ceiling wins if floor set above it
        end
        return r;
    endfunction : bound_code

    // pick one of four 12-bit constants by a 2-bit code
    function automatic logic [11:0] pick4(input logic [1:0] c,
        input logic [11:0] a, input logic [11:0] b,
        input logic [11:0] d, input logic [11:0] e);
        logic [11:0] r;
        r = a;
        if (c == 2'h1) begin
            r = b;
        end else if (c == 2'h2) begin
            r = d;
        end else if (c == 2'h3) begin
            r = e;
        end
        return r;
    endfunction : pick4

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    logic [7:0] adaptCtrl; // on, trigger, spare bits
    logic [7:0] currentFloor; // lower bound code
    logic [7:0] currentCeiling; // upper bound code
    logic [7:0] learnTune; // drop bits, increment, dwell
    logic [7:0] liveCode; // live current value
    logic [7:0] rescaleCtrl; // supply rescale control
    logic [7:0] spare; // spare storage
    logic [7:0] qdMain; // quiet decay main control
    logic [7:0] qdProp; // quiet decay proportional gain
    logic [7:0] qdInt; // quiet decay integral gain
    logic [7:0] qdDiv; // quiet decay gain dividers
    logic [7:0] qdThr; // quiet decay threshold
    logic [7:0] learnBase; // learn base level code
    acqd_learn_type learnState; // learning phase
    logic [5:0] dwellCount; // half-cycles spent at level
    logic [11:0] pwmCount; // switching period counter

    // --------------------------------------------------------------
    // bus decode
    // --------------------------------------------------------------
    wire logic [7:0] regIndex = paddr[9:2]; // word index
    wire logic aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    wire logic setupPhase = psel && !penable; // first apb cycle
    wire logic writeDone = psel && penable && pready && pwrite;
    wire logic hitAdapt = aligned && regIndex == `ACQD_IDX_ADAPT_CTRL;
    wire logic hitFloor = aligned && regIndex == `ACQD_IDX_FLOOR;
    wire logic hitCeil = aligned && regIndex == `ACQD_IDX_CEILING;
    wire logic hitTune = aligned && regIndex == `ACQD_IDX_LEARN_TUNE;
    wire logic hitLive = aligned && regIndex == `ACQD_IDX_LIVE;
    wire logic hitRescale = aligned && regIndex == `ACQD_IDX_RESCALE;
    wire logic hitSpare = aligned && regIndex == `ACQD_IDX_SPARE;
    wire logic hitMain = aligned && regIndex == `ACQD_IDX_QD_MAIN;
    wire logic hitProp = aligned && regIndex == `ACQD_IDX_QD_PROP;
    wire logic hitInt = aligned && regIndex == `ACQD_IDX_QD_INT;
    wire logic hitDiv = aligned && regIndex == `ACQD_IDX_QD_DIV;
    wire logic hitThr = aligned && regIndex == `ACQD_IDX_QD_THR;
    wire logic hitBase = aligned && regIndex == `ACQD_IDX_LEARN_BASE;
    wire logic mapped = hitAdapt | hitFloor | hitCeil | hitTune
        | hitLive | hitRescale | hitSpare | hitMain | hitProp
        | hitInt | hitDiv | hitThr | hitBase;
    // read mux, narrow data sits in the low byte
    wire logic [7:0] readByte =
        ({8{hitAdapt}} & adaptCtrl) | ({8{hitFloor}} & currentFloor)
        | ({8{hitCeil}} & currentCeiling) | ({8{hitTune}} & learnTune)
        | ({8{hitLive}} & liveCode) | ({8{hitRescale}} & rescaleCtrl)
        | ({8{hitSpare}} & spare) | ({8{hitMain}} & qdMain)
        | ({8{hitProp}} & qdProp) | ({8{hitInt}} & qdInt)
        | ({8{hitDiv}} & qdDiv) | ({8{hitThr}} & qdThr)
        | ({8{hitBase}} & learnBase);
    wire logic [7:0] wByte = pwdata[7:0]; // write byte

    // --------------------------------------------------------------
    // field views and learning arithmetic
    // --------------------------------------------------------------
    wire logic adaptEnable = adaptCtrl[`ACQD_ADAPT_ON_BIT];
    wire logic [3:0] dropBits = learnTune[7:4];
    wire logic [1:0] stepCode = learnTune[3:2];
    wire logic [1:0] dwellCode = learnTune[1:0];
    // code 00 is the largest step, the rest rise by doubling
    wire logic [7:0] stepSize = (stepCode == 2'h0) ? 8'h80 :
        (stepCode == 2'h1) ? 8'h10 :
        (stepCode == 2'h2) ? 8'h20 : 8'h40;
    wire logic [10:0] initialLevel =
        11'(learnBase * `ACQD_BASE_MULT);
    wire logic [10:0] finalLevel =
        initialLevel + 11'(stepSize);
    // dwell is (code+1) times eight half-cycles
    wire logic [5:0] dwellTarget =
        6'((dwellCode + 3'h1) * `ACQD_DWELL_UNIT);
    wire logic dwellDone = halfCycleTick
        && (dwellCount + 6'h1 == dwellTarget);
    wire logic launch = writeDone && hitAdapt
        && wByte[`ACQD_TRIGGER_BIT];
    // with the rescale bit set, a supply change during learning restarts it so levels are relearnt
    wire logic rescaleHit = rescaleCtrl[`ACQD_RESCALE_BIT]
        && supplyChange && (learnState != LEARN_IDLE);
    wire logic learnFinish = (learnState == LEARN_FINAL) && dwellDone
        && !rescaleHit;
    wire logic [7:0] boundedDemand =
        bound_code(loopDemand, currentFloor, currentCeiling);
    wire logic [11:0] periodSel = pick4(qdMain[3:2], 12'(PERIOD0),
        12'(PERIOD1), 12'(PERIOD2), 12'(PERIOD3));
    wire logic [11:0] sampleSel = pick4(qdMain[7:6], 12'(SAMPLE0),
        12'(SAMPLE1), 12'(SAMPLE2), 12'(SAMPLE3));

    // --------------------------------------------------------------
    // apb answer: data captured in setup, ready in access
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase; // one wait-free access cycle
            pslverr <= setupPhase && !mapped;
            if (setupPhase) begin
                prdata <= {24'h0, readByte};
            end
        end
    end

    // --------------------------------------------------------------
    // software-written registers, all bits stored as written
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            currentFloor <= `ACQD_RST_FLOOR;
            currentCeiling <= `ACQD_RST_CEILING;
            learnTune <= `ACQD_RST_LEARN_TUNE;
            rescaleCtrl <= `ACQD_RST_RESCALE;
            spare <= `ACQD_RST_SPARE;
            learnBase <= `ACQD_RST_LEARN_BASE;
        end else if (writeDone) begin
            if (hitFloor) currentFloor <= wByte;
            if (hitCeil) currentCeiling <= wByte;
            if (hitTune) learnTune <= wByte;
            if (hitRescale) rescaleCtrl <= wByte;
            if (hitSpare) spare <= wByte;
            if (hitBase) learnBase <= wByte;
        end
    end

    // quiet decay group: every register reads back what was written
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            qdMain <= `ACQD_RST_QD_MAIN;
            qdProp <= `ACQD_RST_QD_PROP;
            qdInt <= `ACQD_RST_QD_INT;
            qdDiv <= `ACQD_RST_QD_DIV;
            qdThr <= `ACQD_RST_QD_THR;
        end else if (writeDone) begin
            if (hitMain) qdMain <= wByte;
            if (hitProp) qdProp <= wByte;
            if (hitInt) qdInt <= wByte;
            if (hitDiv) qdDiv <= wByte;
            if (hitThr) qdThr <= wByte;
        end
    end

    // adaptive control: trigger set by software wins over self-clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            adaptCtrl <= `ACQD_RST_ADAPT_CTRL;
        end else if (writeDone && hitAdapt) begin
            adaptCtrl <= wByte;
        end else if (learnFinish) begin
            adaptCtrl[`ACQD_TRIGGER_BIT] <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // learning sequence
    // --------------------------------------------------------------
    // initial level, dwell, final level, dwell, then idle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            learnState <= LEARN_IDLE;
            dwellCount <= 6'h0;
        end else if (launch || rescaleHit) begin
            learnState <= LEARN_INITIAL;
            dwellCount <= 6'h0;
        end else begin
            unique case (learnState)
                LEARN_IDLE: begin
                    dwellCount <= 6'h0;
                end
                LEARN_INITIAL: begin
                    if (dwellDone) begin
                        learnState <= LEARN_FINAL;
                        dwellCount <= 6'h0;
                    end else if (halfCycleTick) begin
                        dwellCount <= dwellCount + 6'h1;
                    end
                end
                LEARN_FINAL: begin
                    if (dwellDone) begin
                        learnState <= LEARN_IDLE;
                        dwellCount <= 6'h0;
                    end else if (halfCycleTick) begin
                        dwellCount <= dwellCount + 6'h1;
                    end
                end
            endcase
        end
    end

    // learning outputs follow the phase one cycle later
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            learnLevel <= 11'h0;
            learnActive <= 1'b0;
        end else begin
            learnActive <= (learnState != LEARN_IDLE);
            learnLevel <= (learnState == LEARN_FINAL) ? finalLevel :
                (learnState == LEARN_INITIAL) ? initialLevel :
                11'h0;
        end
    end

    // --------------------------------------------------------------
    // live current code and loop error
    // --------------------------------------------------------------
    // bus writes never reach liveCode; it takes the bounded loop demand, or the ceiling while adaptive is off
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            liveCode <= `ACQD_RST_LIVE;
            appliedCurrent <= `ACQD_RST_LIVE;
            adaptiveOn <= 1'b0;
            loopErrorTrunc <= 16'h0;
        end else begin
            liveCode <= adaptEnable ? boundedDemand
                : currentCeiling;
            appliedCurrent <= adaptEnable ? boundedDemand
                : currentCeiling;
            adaptiveOn <= adaptEnable;
            // arithmetic shift keeps the error's sign
            loopErrorTrunc <= 16'($signed(loopError) >>> dropBits);
        end
    end

    // --------------------------------------------------------------
    // quiet decay timing
    // --------------------------------------------------------------
    // counter idles at zero while the mode is off
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwmCount <= 12'h0;
            pwmTick <= 1'b0;
            quietDecayOn <= 1'b0;
            sampleCycles <= 10'h0;
        end else begin
            quietDecayOn <= qdMain[`ACQD_QD_EN_BIT];
            sampleCycles <= sampleSel[9:0];
            if (!qdMain[`ACQD_QD_EN_BIT]) begin
                pwmCount <= 12'h0;
                pwmTick <= 1'b0;
            end else if (pwmCount + 12'h1 >= periodSel) begin
                pwmCount <= 12'h0;
                pwmTick <= 1'b1;
            end else begin
                pwmCount <= pwmCount + 12'h1;
                pwmTick <= 1'b0;
            end
        end
    end
endmodule : acqd_regs
